/* File: design/spbm_seq.sv */
// Request buffer and sequencer that drives one multiplier slice over the link
`timescale 1ns/100ps
module spbm_fifo #(
	parameter int W     = 16,
	parameter int DEPTH = 16
)(
	input  wire logic         clk,
	input  wire logic         arst_n,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);

	localparam int AW = $clog2(DEPTH);

	logic [W-1:0] mem [DEPTH];
	logic [AW:0]  wr_ptr;
	logic [AW:0]  rd_ptr;
	logic         full;
	logic         empty;

	// Extra pointer bit tells full from empty; depth must be a power of two
	assign empty     = (wr_ptr == rd_ptr);
	assign full      = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
	assign in_ready  = ~full;
	assign out_valid = ~empty;
	assign out_data  = mem[rd_ptr[AW-1:0]];

	// Write side
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wr_ptr <= '0;
		end else if (in_valid && !full) begin
			wr_ptr <= wr_ptr + 1'b1;
		end
	end

	// Storage has no reset; empty guards every read
	always_ff @(posedge clk) begin
		if (in_valid && !full) begin
			mem[wr_ptr[AW-1:0]] <= in_data;
		end
	end

	// Read side
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rd_ptr <= '0;
		end else if (out_ready && !empty) begin
			rd_ptr <= rd_ptr + 1'b1;
		end
	end

endmodule

module spbm_seq
	import spbm_pkg::*;
#(
	parameter int Y_W   = SPBM_Y_W,
	parameter int DEPTH = SPBM_FIFO_DEPTH
)(
	input  wire logic                    clk,
	input  wire logic                    arst_n,
	input  wire logic                    req_valid,
	output logic                         req_ready,
	input  wire logic [SPBM_X_W-1:0]     req_x,
	input  wire logic [Y_W-1:0]          req_y,
	output logic                         res_valid,
	input  wire logic                    res_ready,
	output logic [SPBM_X_W+Y_W-1:0]      res_prod,
	spbm_if.seq                          lnk
);

	localparam int P_W = SPBM_X_W + Y_W;
	localparam int CW  = $clog2(P_W + 1);
	localparam int RW  = SPBM_X_W + Y_W;
	localparam logic [CW-1:0] LAST_STEP = CW'(P_W - 1);

	spbm_state_type      state;
	logic                f_valid;
	logic                f_ready;
	logic [RW-1:0]       f_data;
	logic [CW-1:0]       cnt;
	logic [Y_W-1:0]      y_sh;
	logic [SPBM_X_W-1:0] x_out;
	logic                clear_n;
	logic [P_W-1:0]      prod;

	// Requests queue up while a product is in flight; full buffer stalls the user
	spbm_fifo #(
		.W     (RW),
		.DEPTH (DEPTH)
	) u_fifo (
		.clk       (clk),
		.arst_n    (arst_n),
		.in_valid  (req_valid),
		.in_ready  (req_ready),
		.in_data   ({req_x, req_y}),
		.out_valid (f_valid),
		.out_ready (f_ready),
		.out_data  (f_data)
	);

	// Only one product at a time; the buffer is drained in idle only
	assign f_ready = (state == SPBM_ST_IDLE);

	// Control sequence: clear and load, m plus n steps, one capture, hand over
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state <= SPBM_ST_IDLE;
			cnt   <= '0;
		end else begin
			case (state)
				SPBM_ST_IDLE: begin
					if (f_valid) begin
						state <= SPBM_ST_LOAD;
					end
				end
				SPBM_ST_LOAD: begin
					state <= SPBM_ST_RUN;
					cnt   <= '0;
				end
				SPBM_ST_RUN: begin
					cnt <= cnt + 1'b1;
					if (cnt == LAST_STEP) begin
						state <= SPBM_ST_CAP;
					end
				end
				SPBM_ST_CAP: begin
					state <= SPBM_ST_DONE;
				end
				SPBM_ST_DONE: begin
					if (res_ready) begin
						state <= SPBM_ST_IDLE;
					end
				end
				default: begin
					state <= SPBM_ST_IDLE;
				end
			endcase
		end
	end

	// Clear is low for exactly the load cycle, with the multiplicand already set up
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			clear_n <= SPBM_CLEAR_RST;
		end else begin
			clear_n <= ~(state == SPBM_ST_IDLE && f_valid);
		end
	end

	// Operands taken from the buffer head on the pop
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			x_out <= '0;
			y_sh  <= '0;
		end else if (state == SPBM_ST_IDLE && f_valid) begin
			x_out <= f_data[RW-1:Y_W];
			y_sh  <= f_data[Y_W-1:0];
		end else if (state == SPBM_ST_RUN) begin
			y_sh <= {y_sh[Y_W-1], y_sh[Y_W-1:1]};
		end
	end

	// Slice output lags one edge, so capture starts at the second step
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			prod <= '0;
		end else if ((state == SPBM_ST_RUN && cnt != '0) || state == SPBM_ST_CAP) begin
			prod <= {lnk.s, prod[P_W-1:1]};
		end
	end

	assign res_valid = (state == SPBM_ST_DONE);
	assign res_prod  = prod;

	// A lone slice is the most significant one
	assign lnk.m       = SPBM_MODE_MS;
	assign lnk.k       = SPBM_EXP_MS;
	assign lnk.x       = x_out;
	assign lnk.y       = y_sh[0];
	assign lnk.clear_n = clear_n;

endmodule

/* File: design/spbm_pkg.sv */
// Shared constants and types for the serial/parallel Booth multiplier slice and its sequencer
package spbm_pkg;

	// Multiplicand width held by one slice
	localparam int SPBM_X_W = 8;
	// Default multiplier width sent by the sequencer
	localparam int SPBM_Y_W = 8;
	// Default depth of the request buffer in front of the sequencer
	localparam int SPBM_FIFO_DEPTH = 16;

	// Link values driven by the sequencer: clear at reset, mode and expansion at all times
	localparam logic SPBM_CLEAR_RST = 1'b0;
	localparam logic SPBM_MODE_MS = 1'b0;
	localparam logic SPBM_EXP_MS = 1'b0;

	// Cell 0 carry is two bits wide so that the subtract correction fits
	localparam int SPBM_C0_W = 2;
	// Width of the cell 0 column total
	localparam int SPBM_TOT_W = 3;

	// Booth step taken on an edge
	typedef enum logic [1:0] {
		SPBM_OP_SHIFT,
		SPBM_OP_ADD,
		SPBM_OP_SUB
	} spbm_op_type;

	// Sequencer states
	typedef enum logic [2:0] {
		SPBM_ST_IDLE,
		SPBM_ST_LOAD,
		SPBM_ST_RUN,
		SPBM_ST_CAP,
		SPBM_ST_DONE
	} spbm_state_type;

endpackage

/* File: design/spbm_if.sv */
// Link between one multiplier slice and its sequencer or neighbouring slices
`timescale 1ns/100ps
interface spbm_if
	import spbm_pkg::*;
	();

	logic [SPBM_X_W-1:0] x;
	logic                y;
	logic                clear_n;
	logic                k;
	logic                m;
	logic                s;

	modport slice (
		input  x,
		input  y,
		input  clear_n,
		input  k,
		input  m,
		output s
	);

	modport seq (
		output x,
		output y,
		output clear_n,
		output k,
		output m,
		input  s
	);

endinterface

/* File: design/spbm_slice.sv */
// Eight-bit by one-bit serial/parallel Booth multiplier slice
// The array is carry-save: every cell keeps its own carry and passes its sum one place
// down on each edge, so no carry ever has to ripple across slices. That is what lets a
// registered output of one slice feed the expansion input of the next.
`timescale 1ns/100ps
module spbm_slice
	import spbm_pkg::*;
#(
	// Set only in the slice holding the least significant multiplicand bits
	parameter bit LSB_SLICE = 1'b1
)(
	input  wire logic                clk,
	input  wire logic                arst_n,
	spbm_if.slice                    lnk,
	output logic [SPBM_X_W-1:0]      held_x,
	output spbm_op_type              last_op,
	output logic                     cleared
);

	// Combined asynchronous clear: system reset or link clear
	logic                clr_n;
	// Multiplicand latches
	logic [SPBM_X_W-1:0] x_hold;
	// Previous multiplier bit
	logic                y_prev;
	// Booth decode of the current edge
	logic                do_add;
	logic                do_sub;
	// Selected partial product, bit X_W is the sign extension cell
	logic [SPBM_X_W:0]   pp;
	// Sum bit arriving from the cell above
	logic [SPBM_X_W:0]   above;
	// Sum flip-flops, bit 0 is the product output
	logic [SPBM_X_W:0]   sum_q;
	logic [SPBM_X_W:0]   next_sum;
	// Carry flip-flops of cells 1 up to X_W
	logic [SPBM_X_W:1]   carry_q;
	logic [SPBM_X_W:1]   next_carry;
	// Cell 0 carry and column total
	logic [SPBM_C0_W-1:0]  c0_q;
	logic [SPBM_TOT_W-1:0] tot0;
	// Plus one correction of a subtract step
	logic                inj;
	// Slice holds the most significant bits
	logic                is_ms;

	// The link clear acts like a reset; both must release for the array to run
	assign clr_n = arst_n & lnk.clear_n;

	// Transparent while clear is low, frozen while it is high
	always_latch begin
		if (!arst_n) begin
			x_hold <= '0;
		end else if (!lnk.clear_n) begin
			x_hold <= lnk.x;
		end
	end
	// Latch is closed whenever clear is high, so later changes on x are ignored

	assign held_x = x_hold;
	assign cleared = ~clr_n;

	// Remember the multiplier bit for the next recoding step
	always_ff @(posedge clk or negedge clr_n) begin
		if (!clr_n) begin
			y_prev <= 1'b0;
		end else begin
			y_prev <= lnk.y;
		end
	end

	// Booth recoding of current and previous bit
	assign do_add = ~lnk.y & y_prev;
	assign do_sub = lnk.y & ~y_prev;

	// Mode low marks the slice that must extend the sign
	assign is_ms = ~lnk.m;

	// Subtract is done as inverted multiplicand plus one at the word's LSB;
	// only the lowest slice may add that one, otherwise it counts twice
	assign inj = do_sub & LSB_SLICE;

	// Partial product selection per bit
	genvar gi;
	generate
		for (gi = 0; gi < SPBM_X_W; gi = gi + 1) begin : g_pp
			always_comb begin
				if (do_add) begin
					pp[gi] = x_hold[gi];
				end else if (do_sub) begin
					pp[gi] = ~x_hold[gi];
				end else begin
					pp[gi] = 1'b0;
				end
			end
		end
	endgenerate

	// One extra cell stands for all the sign cells above the top one; they would
	// all hold the same values, so feeding it its own sum models them exactly
	always_comb begin
		if (is_ms) begin
			pp[SPBM_X_W]    = pp[SPBM_X_W-1];
			above[SPBM_X_W] = sum_q[SPBM_X_W];
		end else begin
			pp[SPBM_X_W]    = 1'b0;
			above[SPBM_X_W] = 1'b0;
		end
	end

	// Top multiplicand cell takes the expansion input in a cascade
	always_comb begin
		if (is_ms) begin
			above[SPBM_X_W-1] = sum_q[SPBM_X_W];
		end else begin
			above[SPBM_X_W-1] = lnk.k;
		end
	end

	// Lower cells take the sum of the cell above, which is the shift
	generate
		for (gi = 0; gi < SPBM_X_W-1; gi = gi + 1) begin : g_above
			assign above[gi] = sum_q[gi+1];
		end
	endgenerate

	// Full adder cells 1 up to X_W, carries stay in place between edges
	generate
		for (gi = 1; gi <= SPBM_X_W; gi = gi + 1) begin : g_cell
			assign next_sum[gi]   = pp[gi] ^ above[gi] ^ carry_q[gi];
			assign next_carry[gi] = (pp[gi] & above[gi]) | (pp[gi] & carry_q[gi])
				| (above[gi] & carry_q[gi]);

			always_ff @(posedge clk or negedge clr_n) begin
				if (!clr_n) begin
					sum_q[gi]   <= 1'b0;
					carry_q[gi] <= 1'b0;
				end else begin
					sum_q[gi]   <= next_sum[gi];
					carry_q[gi] <= next_carry[gi];
				end
			end
		end
	endgenerate

	// Cell 0 has four inputs; its carry of up to two never exceeds two bits
	assign tot0 = SPBM_TOT_W'(pp[0]) + SPBM_TOT_W'(above[0]) + SPBM_TOT_W'(c0_q)
		+ SPBM_TOT_W'(inj);
	assign next_sum[0] = tot0[0];

	// Cell 0 sum is the product bit of this step
	always_ff @(posedge clk or negedge clr_n) begin
		if (!clr_n) begin
			sum_q[0] <= 1'b0;
			c0_q     <= '0;
		end else begin
			sum_q[0] <= next_sum[0];
			c0_q     <= tot0[SPBM_TOT_W-1:1];
		end
	end

	// Product output straight from the cell 0 flip-flop
	assign lnk.s = sum_q[0];

	// Step record for observation, cleared with the array
	always_ff @(posedge clk or negedge clr_n) begin
		if (!clr_n) begin
			last_op <= SPBM_OP_SHIFT;
		end else if (do_add) begin
			last_op <= SPBM_OP_ADD;
		end else if (do_sub) begin
			last_op <= SPBM_OP_SUB;
		end else begin
			last_op <= SPBM_OP_SHIFT;
		end
	end

endmodule

/* File: bench/spbm_chk.sv */
// Link assertions for the sequencer driving one slice
`timescale 1ns/100ps
module spbm_chk
	import spbm_pkg::*;
(
	input wire logic                clk,
	input wire logic                arst_n,
	input wire logic [SPBM_X_W-1:0] x,
	input wire logic                y,
	input wire logic                clear_n,
	input wire logic                k,
	input wire logic                m,
	input wire logic                s
);
	logic [SPBM_X_W-1:0] xl;
	logic                any_y;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);

	// Multiplicand as latched, and whether a one has entered since clear
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			xl <= 8'h00;
			any_y <= 1'b0;
		end else if (!clear_n) begin
			xl <= x;
			any_y <= 1'b0;
		end else if (y) begin
			any_y <= 1'b1;
		end
	end

	// Clear pulse then release: the start of one product
	sequence s_load;
		$fell(clear_n) ##[1:2] $rose(clear_n);
	endsequence

	property p_clr_zero;
		!clear_n |-> !s;
	endproperty
	a_clr_zero: assert property (p_clr_zero)
		else $error("product bit high in clear");

	property p_clr_short;
		$fell(clear_n) |-> ##[1:2] clear_n;
	endproperty
	a_clr_short: assert property (p_clr_short)
		else $error("clear held too long");

	property p_y_zero;
		clear_n && !any_y && !y |=> !s;
	endproperty
	a_y_zero: assert property (p_y_zero)
		else $error("product bit without multiplier ones");

	property p_x_zero;
		clear_n && ~|xl |=> !s;
	endproperty
	a_x_zero: assert property (p_x_zero)
		else $error("product bit with zero multiplicand");

	property p_lsb;
		s_load ##0 (y && xl[0]) |-> ##[1:2] s;
	endproperty
	a_lsb: assert property (p_lsb)
		else $error("product lsb missing");

	property p_len;
		s_load |-> clear_n [*8] ##1 clear_n [*8];
	endproperty
	a_len: assert property (p_len)
		else $error("run shorter than sixteen edges");

	property p_sign;
		s_load ##7 1'b1 |=> (y == $past(y)) [*8];
	endproperty
	a_sign: assert property (p_sign)
		else $error("multiplier sign not repeated");

	property p_ms_tie;
		!m && !k;
	endproperty
	a_ms_tie: assert property (p_ms_tie)
		else $error("mode or expansion not low");
endmodule

/* File: bench/serial_parallel_booth_multiplier_tb.sv */
// Bench: sequencer and slice on one link, a second slice driven directly, and two more slices driven directly as a cascade
`timescale 1ns/100ps
module serial_parallel_booth_multiplier_tb
	import spbm_pkg::*;
();
	logic        clk;
	logic        arst_n;
	logic        req_valid;
	logic        req_ready;
	logic [7:0]  req_x;
	logic [7:0]  req_y;
	logic        res_valid;
	logic        res_ready;
	logic [15:0] res_prod;
	logic [7:0]  held_x;
	logic        cleared2;
	spbm_op_type last_op;
	spbm_op_type ops [5];
	logic [7:0]  tx [8];
	logic [7:0]  ty [8];
	int          mismatches;
	int          n_tests;
	int          n_acc;
	int          cycles = 0;

	// Serial multiplier pattern for the direct slice, LSB used first
	localparam logic [4:0] YPAT = 5'b10011;

	spbm_if lnk ();
	spbm_if lnk2 ();
	spbm_if lnk3 ();
	spbm_if lnk4 ();

	// Lower slice of the cascade listens to the upper slice's product bit
	assign lnk4.k = lnk3.s;

	spbm_seq u_spbm_seq (
		.clk       (clk),
		.arst_n    (arst_n),
		.req_valid (req_valid),
		.req_ready (req_ready),
		.req_x     (req_x),
		.req_y     (req_y),
		.res_valid (res_valid),
		.res_ready (res_ready),
		.res_prod  (res_prod),
		.lnk       (lnk.seq)
	);
	spbm_slice u_spbm_slice (
		.clk     (clk),
		.arst_n  (arst_n),
		.lnk     (lnk.slice),
		.held_x  (),
		.last_op (),
		.cleared ()
	);
	// Isolated slice so latch and recoding show at its outputs
	spbm_slice u_spbm_slice_2 (
		.clk     (clk),
		.arst_n  (arst_n),
		.lnk     (lnk2.slice),
		.held_x  (held_x),
		.last_op (last_op),
		.cleared (cleared2)
	);
	// Cascade: upper slice holds the sign, lower slice adds the subtract's one
	spbm_slice #(
		.LSB_SLICE (1'b0)
	) u_spbm_slice_3 (
		.clk     (clk),
		.arst_n  (arst_n),
		.lnk     (lnk3.slice),
		.held_x  (),
		.last_op (),
		.cleared ()
	);
	spbm_slice u_spbm_slice_4 (
		.clk     (clk),
		.arst_n  (arst_n),
		.lnk     (lnk4.slice),
		.held_x  (),
		.last_op (),
		.cleared ()
	);
	spbm_chk u_spbm_chk (
		.clk     (clk),
		.arst_n  (arst_n),
		.x       (lnk.x),
		.y       (lnk.y),
		.clear_n (lnk.clear_n),
		.k       (lnk.k),
		.m       (lnk.m),
		.s       (lnk.s)
	);

	// 25 MHz clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task automatic close_out();
		$display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
		if (mismatches == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk_v(input string name, input logic [15:0] exp, input logic [15:0] got);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic chk_op(input spbm_op_type exp, input spbm_op_type got);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] last_op expected %0d seen %0d", exp, got);
		end
	endtask

	task automatic chk_w(input logic [23:0] exp, input logic [23:0] got);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] cascade product expected %h seen %h", exp, got);
		end
	endtask

	function automatic logic [23:0] prodw(input logic [15:0] a, input logic [7:0] b);
		logic signed [23:0] r;
		r = $signed(a) * $signed(b);
		return r;
	endfunction

	// Sixteen-bit multiplicand over two slices, sign repeated to fill 24 edges
	task automatic cascade(input logic [15:0] a, input logic [7:0] b);
		logic [23:0] got;
		got = '0;
		lnk3.x = a[15:8];
		lnk4.x = a[7:0];
		lnk3.clear_n = 1'b0;
		lnk4.clear_n = 1'b0;
		@(posedge clk);
		#1;
		lnk3.clear_n = 1'b1;
		lnk4.clear_n = 1'b1;
		for (int t = 0; t < 24; t++) begin
			lnk3.y = (t < 8) ? b[t] : b[7];
			lnk4.y = (t < 8) ? b[t] : b[7];
			@(posedge clk);
			#1 got[t] = lnk4.s;
		end
		chk_w(prodw(a, b), got);
	endtask

	function automatic logic [15:0] prod(input logic [7:0] a, input logic [7:0] b);
		logic signed [15:0] r;
		r = $signed(a) * $signed(b);
		return r;
	endfunction

	// Leaves valid high so back-to-back pushes never toggle it
	// Ready is looked at while settled, before the edge that takes the request
	task automatic push(input logic [7:0] a, input logic [7:0] b);
		int   n;
		logic ok;
		n = 0;
		req_valid = 1'b1;
		req_x = a;
		req_y = b;
		do begin
			ok = (req_ready === 1'b1);
			@(posedge clk);
			#1;
			n++;
		end while (!ok && n < 60);
	endtask

	// Stalls a while before taking one product
	// Result is taken at the edge where valid and ready are both high
	task automatic pop(input logic [15:0] exp, input int stall);
		int          n;
		logic        v;
		logic [15:0] got;
		n = 0;
		v = 1'b0;
		got = '0;
		if (stall > 0) begin
			res_ready = 1'b0;
			repeat (stall) begin
				@(posedge clk);
				#1;
			end
		end
		res_ready = 1'b1;
		do begin
			v = res_valid;
			got = res_prod;
			@(posedge clk);
			#1;
			n++;
		end while (v !== 1'b1 && n < 60);
		chk_v("res_valid", 16'h0001, 16'(v));
		chk_v("product", exp, got);
	endtask

	// One serial bit into the direct slice; x moves while latches are shut
	task automatic step2(input logic yb, input spbm_op_type exp);
		lnk2.y = yb;
		@(posedge clk);
		#1 chk_op(exp, last_op);
		lnk2.x = ~lnk2.x;
	endtask

	// Hang guard, well above the few hundred cycles needed
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			mismatches++;
			close_out();
		end
	end

	initial begin
		tx = '{8'h00, 8'h01, 8'h80, 8'h7f, 8'hff, 8'h55, 8'h80, 8'h12};
		ty = '{8'h5a, 8'hff, 8'h80, 8'h80, 8'hff, 8'haa, 8'h7f, 8'h00};
		ops = '{SPBM_OP_SUB, SPBM_OP_SHIFT, SPBM_OP_ADD, SPBM_OP_SHIFT, SPBM_OP_SUB};
		mismatches = 0;
		n_tests = 0;
		arst_n = 1'b0;
		req_valid = 1'b0;
		req_x = 8'h00;
		req_y = 8'h00;
		res_ready = 1'b0;
		lnk2.x = 8'h00;
		lnk2.y = 1'b0;
		lnk2.clear_n = 1'b0;
		lnk2.k = 1'b0;
		lnk2.m = 1'b0;
		lnk3.x = 8'h00;
		lnk3.y = 1'b0;
		lnk3.clear_n = 1'b0;
		lnk3.m = 1'b0;
		lnk4.x = 8'h00;
		lnk4.y = 1'b0;
		lnk4.clear_n = 1'b0;
		lnk4.m = 1'b1;
		repeat (3) @(posedge clk);
		#1 arst_n = 1'b1;
		// Corner operands queued back to back, results in order
		for (int i = 0; i < 8; i++)
			push(tx[i], ty[i]);
		req_valid = 1'b0;
		for (int i = 0; i < 8; i++)
			pop(prod(tx[i], ty[i]), 0);
		// Fill until refused while nobody takes results
		res_ready = 1'b0;
		n_acc = 0;
		req_valid = 1'b1;
		for (int i = 0; i < 24; i++) begin
			req_x = 8'(n_acc * 37 + 5);
			req_y = 8'(128 - n_acc);
			if (req_ready === 1'b1)
				n_acc++;
			@(posedge clk);
			#1;
		end
		req_valid = 1'b0;
		chk_v("accepted", 16'h0011, 16'(n_acc));
		for (int j = 0; j < 17; j++)
			pop(prod(8'(j * 37 + 5), 8'(128 - j)), j % 3);
		// Latch open in clear, shut after; every recoding step
		lnk2.x = 8'ha5;
		#5 chk_v("held_x open", 16'h00a5, 16'(held_x));
		@(posedge clk);
		#1 lnk2.clear_n = 1'b1;
		for (int i = 0; i < 5; i++)
			step2(YPAT[i], ops[i]);
		chk_v("held_x shut", 16'h00a5, 16'(held_x));
		lnk2.clear_n = 1'b0;
		#2 chk_op(SPBM_OP_SHIFT, last_op);
		chk_v("s in clear", 16'h0000, 16'(lnk2.s));
		chk_v("cleared", 16'h0001, 16'(cleared2));
		chk_v("held_x reopen", 16'h005a, 16'(held_x));
		@(posedge clk);
		#1 lnk2.clear_n = 1'b1;
		step2(1'b0, SPBM_OP_SHIFT);
		// Two slices in a string, mode high on the lower one
		cascade(16'h8000, 8'h80);
		cascade(16'h1234, 8'hd3);
		cascade(16'hffff, 8'h01);
		close_out();
	end
endmodule
